// >>> card_directory_record_decoder_tb_top.sv
/*
  Self-checking bench for the card directory record server.
  Assumes the reader model stands at the record side and one clock.
*/
`timescale 1ns/1ns
module card_directory_record_decoder_tb_top;
  import cdr_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  cdr_bus_t    bus = '0;
  logic [31:0] rdata;
  cdr_cmd_t    cmd;
  cdr_tx_t     tx;
  cdr_sw_t     sw;
  logic [4:0]  fci_sfi;
  logic        start = 1'b0;
  logic [7:0]  dir_id = 8'h00;
  logic [7:0]  rec_num = 8'h00;
  logic        done;
  logic [15:0] code;
  logic [5:0]  count;
  logic [5:0]  last_pos;
  logic [7:0]  got [0:31];
  logic [7:0]  exp_b [0:31];
  int          err_count = 0;
  int          num_checks = 0;

  always #2 i_clock = ~i_clock;

  cdr_dir_server u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
    .i_cmd(cmd), .o_tx(tx), .o_sw(sw), .o_fci_sfi(fci_sfi));
  cdr_reader_model u_reader (.i_clock(i_clock), .i_rst(i_rst), .i_start(start),
    .i_dir_id(dir_id), .i_rec_num(rec_num), .i_tx(tx), .i_sw(sw), .o_cmd(cmd),
    .o_done(done), .o_code(code), .o_count(count), .o_last_pos(last_pos), .o_bytes(got));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clock);
    bus <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clock);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge i_clock);
    bus <= '0;
    #1;
    chk(rdata, e);
  endtask

  // Identifier pin is a flop behind the control register: one extra edge
  task automatic sfi_chk(input logic [4:0] e);
    @(posedge i_clock);
    #1;
    chk({27'h0, fci_sfi}, {27'h0, e});
  endtask

  task automatic rd_rec(input logic [7:0] d, input logic [7:0] r, input logic [15:0] e,
                        input int n);
    int k;
    @(posedge i_clock);
    start   <= 1'b1;
    dir_id  <= d;
    rec_num <= r;
    @(posedge i_clock);
    start <= 1'b0;
    #1;
    k = 0;
    while (done !== 1'b1 && k < 100) begin
      @(posedge i_clock);
      #1;
      k++;
    end
    if (done !== 1'b1) begin
      err_count++;
      results();
    end else begin
      chk({16'h0000, code}, {16'h0000, e});
      chk({26'h0, count}, n);
      if (n > 0) begin
        chk({26'h0, last_pos}, n - 1);
      end
      for (int i = 0; i < n; i++) begin
        chk({24'h0, got[i]}, {24'h0, exp_b[i]});
      end
    end
  endtask

  task automatic hdr(input logic [7:0] a, b, c, d, e, f);
    exp_b[0] = a;
    exp_b[1] = b;
    exp_b[2] = c;
    exp_b[3] = d;
    exp_b[4] = e;
    exp_b[5] = f;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({27'h0, fci_sfi}, 32'h0000_0000);
    rd_chk(REG_STATUS, 32'h0000_0000);
    rd_chk(8'h20, 32'h0000_0000);
    rd_chk(REG_ENTRY, 32'h0000_0000);
  endtask

  task automatic t_config();
    wr_reg(REG_CTRL, 32'h0000_010A);
    sfi_chk(5'h0A);
    wr_reg(REG_CTRL, 32'h0000_010B);
    sfi_chk(5'h0A);
    rd_chk(REG_STATUS, 32'h0000_0002);
    wr_reg(REG_STATUS, 32'h0000_0000);
    wr_reg(REG_CTRL, 32'h0000_0101);
    sfi_chk(5'h01);
    wr_reg(REG_NUM_REC, 32'h0000_0009);
    rd_chk(REG_STATUS, 32'h0000_0002);
    wr_reg(REG_STATUS, 32'h0000_0000);
    wr_reg(REG_ENTRY, 32'h0000_0400);
    rd_chk(REG_STATUS, 32'h0000_0002);
    wr_reg(REG_STATUS, 32'h0000_0000);
    wr_reg(REG_ENTRY, 32'h0000_1181);
    rd_chk(REG_STATUS, 32'h0000_0002);
    wr_reg(REG_STATUS, 32'h0000_0000);
    rd_chk(REG_STATUS, 32'h0000_0000);
  endtask

  task automatic t_records();
    wr_reg(REG_NUM_REC, 32'h0000_0002);
    wr_reg(REG_ENTRY, 32'h0103_0500);
    wr_reg(REG_PRIO, 32'h0000_F100);
    wr_reg(REG_ENTRY, 32'h0000_1081);
    for (int i = 0; i < 16; i++) begin
      if (i < 5) wr_reg(REG_DATA, {8'h00, 8'hA0 + i[7:0], i[3:0], 12'h000});
      if (i < 3) wr_reg(REG_DATA, {8'h00, 8'hC0 + i[7:0], i[3:0], 12'h100});
      wr_reg(REG_DATA, {8'h00, 8'hB0 + i[7:0], i[3:0], 12'h001});
    end
    hdr(8'h70, 8'h11, 8'h61, 8'h0F, 8'h4F, 8'h05);
    for (int i = 0; i < 5; i++) exp_b[6 + i] = 8'hA0 + i[7:0];
    exp_b[11] = 8'h50;
    exp_b[12] = 8'h03;
    for (int i = 0; i < 3; i++) exp_b[13 + i] = 8'hC0 + i[7:0];
    exp_b[16] = 8'h87;
    exp_b[17] = 8'h01;
    exp_b[18] = 8'h81;
    rd_rec(8'hE1, 8'h01, SW_OK, 19);
    hdr(8'h70, 8'h14, 8'h61, 8'h12, 8'h9D, 8'h10);
    for (int i = 0; i < 16; i++) exp_b[6 + i] = 8'hB0 + i[7:0];
    rd_rec(8'h01, 8'h02, SW_OK, 22);
    rd_chk(REG_STATUS, 32'h9000_0000);
  endtask

  task automatic t_errors();
    rd_rec(8'h01, 8'h03, SW_NO_RECORD, 0);
    rd_chk(REG_STATUS, 32'h6A83_0000);
    rd_rec(8'h01, 8'h00, SW_NO_RECORD, 0);
    rd_rec(8'h02, 8'h01, SW_NO_FILE, 0);
    wr_reg(REG_CTRL, 32'h0000_0001);
    rd_rec(8'h01, 8'h01, SW_NO_FILE, 0);
    wr_reg(REG_CTRL, 32'h0000_0101);
    rd_rec(8'h01, 8'h02, SW_OK, 22);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_config();
    t_records();
    t_errors();
    results();
  end
endmodule

// >>> cdr_dir_server.sv
/*
  Card-side directory record server: holds one directory's entries and
  answers record reads with a tag-length-value byte stream and a status word.
  Assumes commands and register accesses come from logic on i_clock.
*/
`timescale 1ns/1ns
module cdr_dir_server (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire cdr_pkg::cdr_bus_t i_bus,
  output logic [31:0]            o_rdata,
  input  wire cdr_pkg::cdr_cmd_t i_cmd,
  output cdr_pkg::cdr_tx_t       o_tx,
  output cdr_pkg::cdr_sw_t       o_sw,
  output logic [4:0]             o_fci_sfi
);
  import cdr_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [4:0]  dir_sfi;
  logic        ddf_selected;
  logic [3:0]  num_rec;
  logic        bad_cfg;
  logic [15:0] last_sw;
  logic        is_ddf_mem   [NUM_REC];
  logic [4:0]  name_len_mem [NUM_REC];
  logic [4:0]  label_len_mem[NUM_REC];
  logic        prio_p_mem   [NUM_REC];
  logic [7:0]  prio_mem     [NUM_REC];
  logic [7:0]  name_mem     [NUM_REC][NAME_BYTES];
  logic [7:0]  label_mem    [NUM_REC][NAME_BYTES];

  cdr_state_t  state;
  cdr_state_t  next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [2:0]  cur_rec;
  logic [2:0]  next_cur;
  cdr_tx_t     next_tx;
  cdr_sw_t     next_sw;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  logic [2:0] wr_rec;
  logic [4:0] wr_nl;
  logic [4:0] wr_ll;
  logic [4:0] wr_sfi;
  logic       entry_ok;
  logic       sfi_ok;
  assign wr_rec   = i_bus.wdata[2:0];
  assign wr_nl    = i_bus.wdata[ENTRY_NAME_LSB +: 5];
  assign wr_ll    = i_bus.wdata[ENTRY_LABEL_LSB +: 5];
  assign wr_sfi   = i_bus.wdata[4:0];
  assign entry_ok = wr_nl >= NAME_MIN && wr_nl <= NAME_MAX && wr_ll <= LABEL_MAX;
  assign sfi_ok   = wr_sfi >= SFI_MIN && wr_sfi <= SFI_MAX;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      dir_sfi      <= SFI_RESET;
      ddf_selected <= 1'b0;
      num_rec      <= NUM_REC_RESET;
    end else if (i_bus.wr && i_bus.addr == REG_CTRL) begin
      if (sfi_ok) begin
        dir_sfi <= wr_sfi;
      end
      ddf_selected <= i_bus.wdata[CTRL_DDF_SEL];
    end else if (i_bus.wr && i_bus.addr == REG_NUM_REC) begin
      if (i_bus.wdata[3:0] <= NUM_REC_MAX && i_bus.wdata[31:4] == '0) begin
        num_rec <= i_bus.wdata[3:0];
      end
    end
  end

  // Sticky config error; a rejecting write and a clear never coincide
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bad_cfg <= 1'b0;
    end else if (i_bus.wr) begin
      unique case (i_bus.addr)
        REG_CTRL:    bad_cfg <= bad_cfg | ~sfi_ok;
        REG_NUM_REC: bad_cfg <= bad_cfg | (i_bus.wdata > 32'(NUM_REC_MAX));
        REG_ENTRY:   bad_cfg <= bad_cfg | ~entry_ok;
        REG_STATUS:  bad_cfg <= 1'b0;
        default:     bad_cfg <= bad_cfg;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int r = 0; r < NUM_REC; r++) begin
        is_ddf_mem[r]    <= 1'b0;
        name_len_mem[r]  <= NAME_MIN;
        label_len_mem[r] <= 5'h00;
        prio_p_mem[r]    <= 1'b0;
        prio_mem[r]      <= 8'h00;
      end
    end else if (i_bus.wr && i_bus.addr == REG_ENTRY && entry_ok) begin
      is_ddf_mem[wr_rec]    <= i_bus.wdata[ENTRY_IS_DDF];
      name_len_mem[wr_rec]  <= wr_nl;
      label_len_mem[wr_rec] <= wr_ll;
      prio_p_mem[wr_rec]    <= i_bus.wdata[ENTRY_PRIO_BIT];
    end else if (i_bus.wr && i_bus.addr == REG_PRIO) begin
      prio_mem[wr_rec] <= i_bus.wdata[PRIO_VAL_LSB +: 8] & PRIO_KEEP_MASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_bus.wr && i_bus.addr == REG_DATA) begin
      if (i_bus.wdata[DATA_LABEL_BIT]) begin
        label_mem[wr_rec][i_bus.wdata[DATA_IDX_LSB +: 4]] <= i_bus.wdata[DATA_BYTE_LSB +: 8];
      end else begin
        name_mem[wr_rec][i_bus.wdata[DATA_IDX_LSB +: 4]] <= i_bus.wdata[DATA_BYTE_LSB +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        REG_CTRL:    o_rdata <= {23'h00_0000, ddf_selected, 3'h0, dir_sfi};
        REG_NUM_REC: o_rdata <= {28'h000_0000, num_rec};
        REG_STATUS:  o_rdata <= {last_sw, 14'h0000, bad_cfg, state != ST_IDLE};
        default:     o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_fci_sfi <= SFI_RESET;
    end else begin
      o_fci_sfi <= dir_sfi;
    end
  end

  // ----------------------------------------------------------------
  // Record builder
  // ----------------------------------------------------------------
  logic       file_open;
  logic       rec_missing;
  logic [4:0] cur_nl;
  logic [4:0] cur_ll;
  logic       has_label;
  logic       has_prio;
  logic [7:0] entry_len;
  logic [7:0] rec_len;
  assign file_open   = ddf_selected && dir_sfi != SFI_RESET && i_cmd.short_file_id == dir_sfi;
  assign rec_missing = i_cmd.rec_num == 8'h00 || i_cmd.rec_num > {4'h0, num_rec};
  assign cur_nl      = name_len_mem[cur_rec];
  assign cur_ll      = label_len_mem[cur_rec];
  assign has_label   = cur_ll != 5'h00;
  assign has_prio    = prio_p_mem[cur_rec] && !is_ddf_mem[cur_rec];
  assign entry_len   = 8'(8'd2 + {3'h0, cur_nl} + (has_label ? 8'(8'd2 + {3'h0, cur_ll}) : 8'h00)
                       + (has_prio ? 8'd3 : 8'h00));
  assign rec_len     = 8'(entry_len + 8'd2);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_cur   = cur_rec;
    next_tx    = '0;
    next_sw    = '0;
    unique case (state)
      ST_IDLE: begin
        if (i_cmd.valid) begin
          if (!file_open) begin
            next_sw = {1'b1, SW_NO_FILE};
          end else if (rec_missing) begin
            next_sw = {1'b1, SW_NO_RECORD};
          end else begin
            next_tx    = {2'b10, TAG_RECORD};
            next_cur   = 3'(i_cmd.rec_num - 8'd1);
            next_state = ST_REC_LEN;
          end
        end
      end
      ST_REC_LEN: begin
        next_tx    = {2'b10, rec_len};
        next_state = ST_TMPL_TAG;
      end
      ST_TMPL_TAG: begin
        next_tx    = {2'b10, TAG_APP_TMPL};
        next_state = ST_TMPL_LEN;
      end
      ST_TMPL_LEN: begin
        next_tx    = {2'b10, entry_len};
        next_state = ST_NAME_TAG;
      end
      ST_NAME_TAG: begin
        next_tx    = {2'b10, is_ddf_mem[cur_rec] ? TAG_DDF_NAME : TAG_ADF_NAME};
        next_state = ST_NAME_LEN;
      end
      ST_NAME_LEN: begin
        next_tx    = {2'b10, 3'h0, cur_nl};
        next_cnt   = 4'h0;
        next_state = ST_NAME_VAL;
      end
      ST_NAME_VAL: begin
        next_tx  = {2'b10, name_mem[cur_rec][cnt]};
        next_cnt = 4'(cnt + 4'd1);
        if ({1'b0, cnt} == 5'(cur_nl - 5'd1)) begin
          next_cnt = 4'h0;
          if (has_label) begin
            next_state = ST_LABEL_TAG;
          end else if (has_prio) begin
            next_state = ST_PRIO_TAG;
          end else begin
            next_tx.last = 1'b1;
            next_state   = ST_STATUS;
          end
        end
      end
      ST_LABEL_TAG: begin
        next_tx    = {2'b10, TAG_LABEL};
        next_state = ST_LABEL_LEN;
      end
      ST_LABEL_LEN: begin
        next_tx    = {2'b10, 3'h0, cur_ll};
        next_state = ST_LABEL_VAL;
      end
      ST_LABEL_VAL: begin
        next_tx  = {2'b10, label_mem[cur_rec][cnt]};
        next_cnt = 4'(cnt + 4'd1);
        if ({1'b0, cnt} == 5'(cur_ll - 5'd1)) begin
          next_cnt = 4'h0;
          if (has_prio) begin
            next_state = ST_PRIO_TAG;
          end else begin
            next_tx.last = 1'b1;
            next_state   = ST_STATUS;
          end
        end
      end
      ST_PRIO_TAG: begin
        next_tx    = {2'b10, TAG_PRIO};
        next_state = ST_PRIO_LEN;
      end
      ST_PRIO_LEN: begin
        next_tx    = {2'b10, PRIO_LEN};
        next_state = ST_PRIO_VAL;
      end
      ST_PRIO_VAL: begin
        next_tx    = {2'b11, prio_mem[cur_rec]};
        next_state = ST_STATUS;
      end
      ST_STATUS: begin
        next_sw    = {1'b1, SW_OK};
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state   <= ST_IDLE;
      cnt     <= 4'h0;
      cur_rec <= 3'h0;
      o_tx    <= '0;
      o_sw    <= '0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      cur_rec <= next_cur;
      o_tx    <= next_tx;
      o_sw    <= next_sw;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      last_sw <= 16'h0000;
    end else if (next_sw.valid) begin
      last_sw <= next_sw.code;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence seq_accept;
    state == ST_IDLE && i_cmd.valid && file_open && !rec_missing;
  endsequence
  sequence seq_head;
    o_tx.valid && o_tx.data == TAG_RECORD ##1 o_tx.valid ##1 o_tx.data == TAG_APP_TMPL;
  endsequence

  chk_record_head: assert property (seq_accept |-> ##1 seq_head)
    else $error("record does not open with 70 then 61");
  chk_no_record: assert property (state == ST_IDLE && i_cmd.valid && file_open && rec_missing
    |-> ##1 o_sw.valid && o_sw.code == SW_NO_RECORD && !o_tx.valid)
    else $error("missing record not answered with 6A83");
  chk_ddf_gate: assert property (state == ST_IDLE && i_cmd.valid && !ddf_selected
    |-> ##1 o_sw.valid && o_sw.code == SW_NO_FILE)
    else $error("read allowed without directory file selected");
  chk_sfi_window: assert property (o_tx.valid |-> dir_sfi >= SFI_MIN && dir_sfi <= SFI_MAX)
    else $error("record sent with identifier out of range");
  chk_name_tag: assert property (state == ST_NAME_TAG |-> ##1 o_tx.data
    == (is_ddf_mem[$past(cur_rec)] ? TAG_DDF_NAME : TAG_ADF_NAME))
    else $error("name tag does not match entry kind");
  chk_name_span: assert property (state == ST_NAME_LEN
    |-> ##1 o_tx.data >= 8'(NAME_MIN) && o_tx.data <= 8'(NAME_MAX))
    else $error("name length outside 5 to 16");
  chk_entry_whole: assert property (o_tx.valid && o_tx.last
    |-> ##1 o_sw.valid && o_sw.code == SW_OK ##1 !o_tx.valid)
    else $error("record not closed by 9000 after last byte");
  chk_prio_rsvd: assert property (state == ST_PRIO_VAL
    |-> ##1 o_tx.last && o_tx.data[6:4] == 3'h0)
    else $error("priority reserved bits not zero");
  chk_confirm_bit: assert property (state == ST_PRIO_VAL
    |-> ##1 o_tx.data[7] == $past(prio_mem[cur_rec][7]))
    else $error("confirmation bit lost");
  chk_one_record: assert property (state != ST_IDLE && state != ST_STATUS
    |-> !o_sw.valid || o_sw.code != SW_OK)
    else $error("status issued inside a record");

endmodule

// >>> cdr_pkg.sv
/*
  Package of the card directory record decoder's card side: tags, status words,
  register map, field positions, reset values, carrier structs and FSM states.
  Assumes a single clock domain and a plain register port.
*/
// Functional notes
// - Directory short_file_id lies within 1 to 10
// - short_file_id offered for file_control_info
// - One record returned per read command
// - Entry never split across two records
// - Record tag 70 wraps templates tagged 61
// - No extra elements outside template 73
// - Sub-directory entry: name 9D, 5-16 bytes
// - Application entry: name 4F, label 50
// - Priority bit b8 means confirmation needed
// - Priority b4-b1 order, b7-b5 reserved
// - Reads allowed only while directory file selected
// - All directory levels share one layout
// - Past last record answer 6A83
package cdr_pkg;

  // ----------------------------------------------------------------
  // Tags and status words
  // ----------------------------------------------------------------
  localparam logic [7:0]  TAG_RECORD      = 8'h70;
  localparam logic [7:0]  TAG_APP_TMPL    = 8'h61;
  localparam logic [7:0]  TAG_ADF_NAME    = 8'h4F;
  localparam logic [7:0]  TAG_DDF_NAME    = 8'h9D;
  localparam logic [7:0]  TAG_LABEL       = 8'h50;
  localparam logic [7:0]  TAG_PRIO        = 8'h87;
  localparam logic [15:0] SW_OK           = 16'h9000;
  localparam logic [15:0] SW_NO_RECORD    = 16'h6A83;
  localparam logic [15:0] SW_NO_FILE      = 16'h6A82;

  // ----------------------------------------------------------------
  // Sizes and limits
  // ----------------------------------------------------------------
  localparam int          NUM_REC         = 8;
  localparam int          NAME_BYTES      = 16;
  localparam logic [4:0]  SFI_MIN         = 5'h01;
  localparam logic [4:0]  SFI_MAX         = 5'h0A;
  localparam logic [4:0]  NAME_MIN        = 5'h05;
  localparam logic [4:0]  NAME_MAX        = 5'h10;
  localparam logic [4:0]  LABEL_MAX       = 5'h10;
  localparam logic [3:0]  NUM_REC_MAX     = 4'h8;
  localparam logic [7:0]  PRIO_KEEP_MASK  = 8'h8F;
  localparam logic [7:0]  PRIO_LEN        = 8'h01;

  // ----------------------------------------------------------------
  // Register offsets, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_NUM_REC     = 8'h04;
  localparam logic [7:0]  REG_ENTRY       = 8'h08;
  localparam logic [7:0]  REG_PRIO        = 8'h0C;
  localparam logic [7:0]  REG_DATA        = 8'h10;
  localparam logic [7:0]  REG_STATUS      = 8'h14;
  localparam int          CTRL_DDF_SEL    = 8;
  localparam int          ENTRY_IS_DDF    = 7;
  localparam int          ENTRY_NAME_LSB  = 8;
  localparam int          ENTRY_LABEL_LSB = 16;
  localparam int          ENTRY_PRIO_BIT  = 24;
  localparam int          PRIO_VAL_LSB    = 8;
  localparam int          DATA_LABEL_BIT  = 8;
  localparam int          DATA_IDX_LSB    = 12;
  localparam int          DATA_BYTE_LSB   = 16;
  localparam int          STAT_BAD_BIT    = 1;
  localparam int          STAT_SW_LSB     = 16;
  localparam logic [4:0]  SFI_RESET       = 5'h00;
  localparam logic [3:0]  NUM_REC_RESET   = 4'h0;

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } cdr_bus_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] short_file_id;
    logic [7:0] rec_num;
  } cdr_cmd_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } cdr_tx_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] code;
  } cdr_sw_t;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_REC_LEN   = 4'b0001,
    ST_TMPL_TAG  = 4'b0010,
    ST_TMPL_LEN  = 4'b0011,
    ST_NAME_TAG  = 4'b0100,
    ST_NAME_LEN  = 4'b0101,
    ST_NAME_VAL  = 4'b0110,
    ST_LABEL_TAG = 4'b0111,
    ST_LABEL_LEN = 4'b1000,
    ST_LABEL_VAL = 4'b1001,
    ST_PRIO_TAG  = 4'b1010,
    ST_PRIO_LEN  = 4'b1011,
    ST_PRIO_VAL  = 4'b1100,
    ST_STATUS    = 4'b1101
  } cdr_state_t;

endpackage

// >>> cdr_reader_model.sv
/*
  Reader-side partner: issues record reads and collects the returned bytes.
  Assumes the card server runs on the same clock and pulses its outputs.
*/
`timescale 1ns/1ns
module cdr_reader_model (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_start,
  input  wire logic [7:0]       i_dir_id,
  input  wire logic [7:0]       i_rec_num,
  input  wire cdr_pkg::cdr_tx_t i_tx,
  input  wire cdr_pkg::cdr_sw_t i_sw,
  output cdr_pkg::cdr_cmd_t     o_cmd,
  output logic                  o_done,
  output logic [15:0]           o_code,
  output logic [5:0]            o_count,
  output logic [5:0]            o_last_pos,
  output logic [7:0]            o_bytes [0:31]
);
  import cdr_pkg::*;
  // ----------------------------------------------------------------
  // Command issue
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_cmd <= '0;
    end else begin
      o_cmd.valid   <= i_start;
      o_cmd.short_file_id     <= i_dir_id[4:0];
      o_cmd.rec_num <= i_rec_num;
    end
  end
  // ----------------------------------------------------------------
  // Response capture, raw and never rejected
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_done     <= 1'b0;
      o_code     <= '0;
      o_count    <= '0;
      o_last_pos <= '1;
    end else if (i_start) begin
      o_done     <= 1'b0;
      o_count    <= '0;
      o_last_pos <= '1;
    end else begin
      if (i_tx.valid) begin
        o_bytes[o_count] <= i_tx.data;
        o_count          <= o_count + 6'h01;
        if (i_tx.last) begin
          o_last_pos <= o_count;
        end
      end
      if (i_sw.valid) begin
        o_done <= 1'b1;
        o_code <= i_sw.code;
      end
    end
  end
endmodule
